// >>> hw/txq_ctrl.sv
/*
 Control and status of the priority transmit queue and one general
 message FIFO, plus the 32-word object FIFO feeding the protocol
 engine. Assumes the engine reports completions as one-cycle pulses
 and that the host port is synchronous to core_clk_i.
*/
`timescale 1ns/1ps

// ==========================================================
// Object FIFO
module obj_fifo #(
   parameter int W = 32,
   parameter int D = 32
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic clear_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] fill;
   logic push;
   logic pop;

   assign in_ready_o = fill < (AW+1)'(D);
   assign out_valid_o = fill != '0;
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge core_clk_i) begin
      if (ce_i && push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || (ce_i && clear_i)) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
      end else if (ce_i) begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : obj_fifo

// ==========================================================
// Queue control
module txq_ctrl
   import txq_pkg::*;
(
   // Clock, reset, enable
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Controller mode
   input wire logic cfg_mode_i,
   input wire logic global_retry_limit_enable_i,
   // Host register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [2:0] reg_index_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Engine events, bit 0 queue, bit 1 FIFO
   input wire logic [1:0] msg_done_i,
   input wire logic [1:0] aborted_i,
   input wire logic [1:0] arb_lost_i,
   input wire logic [1:0] bus_err_i,
   input wire logic [1:0] attempts_out_i,
   input wire logic remote_req_i,
   // Engine controls
   output logic [1:0] send_pending_o,
   output logic [1:0] abort_req_o,
   output logic [3:0] retry_limit_o,
   output logic [13:0] payload_bytes_o,
   output logic next_queue_o,
   output logic rx_ts_write_o,
   output logic irq_o,
   // Queue objects toward engine
   output logic obj_valid_o,
   input wire logic obj_ready_i,
   output logic [FIFO_W-1:0] obj_addr_o
);
   logic [31:0] ctl [Q_N];
   logic [4:0] head [Q_N];
   logic [4:0] tail [Q_N];
   logic [5:0] cnt [Q_N];
   logic [3:0] stk [Q_N];
   logic [Q_N-1:0] req;
   logic [Q_N-1:0] clr;
   logic ovf;
   logic [Q_N-1:0] dir, full, empty, wr_ctl, wr_sta, adv, done;
   logic [Q_N-1:0] push, pop, do_rst;
   logic [5:0] cap [Q_N];
   logic [31:0] head_addr;
   logic fifo_in_ready;
   logic [31:0] next_rdata;
   logic [5:0] ev;

   // Payload bytes per object from the payload code
   function automatic logic [6:0] pay_bytes(input logic [2:0] code);
      case (code)
         3'h0: pay_bytes = 7'd8;
         3'h1: pay_bytes = 7'd12;
         3'h2: pay_bytes = 7'd16;
         3'h3: pay_bytes = 7'd20;
         3'h4: pay_bytes = 7'd24;
         3'h5: pay_bytes = 7'd32;
         3'h6: pay_bytes = 7'd48;
         default: pay_bytes = 7'd64;
      endcase
   endfunction : pay_bytes

   // Pointer step with wrap at the last configured object
   function automatic logic [4:0] step(input logic [4:0] p, input logic [4:0] last);
      step = (p == last) ? 5'h00 : p + 5'h01;
   endfunction : step

   // ==========================================================
   // Per-queue decode
   always_comb begin
      for (int q = 0; q < Q_N; q++) begin
         dir[q] = (q == 0) ? 1'b1 : ctl[q][B_DIR];
         cap[q] = {1'b0, ctl[q][B_DEP+:5]} + 6'h01;
         full[q] = cnt[q] == cap[q];
         empty[q] = cnt[q] == 6'h00;
         wr_ctl[q] = reg_wr_i && reg_index_i == ((q == 0) ? IDX_QCON : IDX_FCON);
         wr_sta[q] = reg_wr_i && reg_index_i == ((q == 0) ? IDX_QSTA : IDX_FSTA);
         do_rst[q] = clr[q] && !cfg_mode_i;
         adv[q] = wr_ctl[q] && reg_wdata_i[B_ADV] && !clr[q];
         // Queue completes on the object handshake, not on the done pulse
         done[q] = (q == 0) ? (obj_valid_o && obj_ready_i) : msg_done_i[q];
         if (dir[q]) begin
            // Host fills at head, engine drains at tail
            push[q] = adv[q] && !full[q] && (q != 0 || fifo_in_ready);
            pop[q] = done[q] && !empty[q];
         end else begin
            push[q] = done[q] && !full[q];
            pop[q] = adv[q] && !empty[q];
         end
      end
   end

   // ==========================================================
   // Control words
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         for (int q = 0; q < Q_N; q++) begin
            ctl[q] <= CTL_RST;
         end
      end else if (ce_i) begin
         for (int q = 0; q < Q_N; q++) begin
            if (wr_ctl[q]) begin
               logic [31:0] m;
               m = (cfg_mode_i ? (CFG_ONLY | ANY_MODE) : ANY_MODE)
                  & ((q == 0) ? TXQ_BITS : 32'hFFFF_FFFF);
               ctl[q] <= (ctl[q] & ~m) | (reg_wdata_i & m);
            end
         end
      end
   end

   // ==========================================================
   // Pointers and counts
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         for (int q = 0; q < Q_N; q++) begin
            head[q] <= 5'h00;
            tail[q] <= 5'h00;
            cnt[q] <= 6'h00;
         end
      end else if (ce_i) begin
         for (int q = 0; q < Q_N; q++) begin
            if (do_rst[q] || cfg_mode_i) begin
               head[q] <= 5'h00;
               tail[q] <= 5'h00;
               cnt[q] <= 6'h00;
            end else begin
               if (push[q]) begin
                  head[q] <= step(head[q], ctl[q][B_DEP+:5]);
               end
               if (pop[q]) begin
                  tail[q] <= step(tail[q], ctl[q][B_DEP+:5]);
               end
               cnt[q] <= cnt[q] + 6'(push[q]) - 6'(pop[q]);
            end
         end
      end
   end

   // ==========================================================
   // Clear requests
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         clr <= '1;
      end else if (ce_i) begin
         for (int q = 0; q < Q_N; q++) begin
            if (cfg_mode_i) begin
               clr[q] <= 1'b1;
            end else if (do_rst[q]) begin
               clr[q] <= 1'b0;
            end else if (wr_ctl[q] && reg_wdata_i[B_CLR]) begin
               clr[q] <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Send requests and abort pulses
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         req <= '0;
         abort_req_o <= '0;
      end else if (ce_i) begin
         for (int q = 0; q < Q_N; q++) begin
            abort_req_o[q] <= 1'b0;
            if (do_rst[q] || !dir[q]) begin
               req[q] <= 1'b0;
            end else if ((wr_ctl[q] && reg_wdata_i[B_REQ])
               || (q == 1 && remote_req_i && ctl[q][B_RTR])) begin
               req[q] <= 1'b1;
            end else if (aborted_i[q]) begin
               req[q] <= 1'b0;
            end else if (pop[q] && cnt[q] == 6'h01 && !push[q]) begin
               req[q] <= 1'b0;
            end else if (wr_ctl[q] && req[q]) begin
               abort_req_o[q] <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Sticky status flags, set wins over host clear
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         for (int q = 0; q < Q_N; q++) begin
            stk[q] <= 4'h0;
         end
         ovf <= 1'b0;
      end else if (ce_i) begin
         for (int q = 0; q < Q_N; q++) begin
            if (do_rst[q]) begin
               stk[q] <= 4'h0;
            end else begin
               stk[q] <= (stk[q] & (wr_sta[q] ? reg_wdata_i[B_ATF+:4] : 4'hF))
                  | {aborted_i[q], arb_lost_i[q], bus_err_i[q], attempts_out_i[q]};
            end
         end
         if (do_rst[1]) begin
            ovf <= 1'b0;
         end else begin
            ovf <= (ovf && !(wr_sta[1] && !reg_wdata_i[B_OVF]))
               || (done[1] && !dir[1] && full[1]);
         end
      end
   end

   // ==========================================================
   // Object FIFO toward engine
   obj_fifo #(
      .W(FIFO_W),
      .D(FIFO_D)
   ) u_obj_fifo (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .clear_i(do_rst[0] || cfg_mode_i),
      .in_valid_i(push[0]),
      .in_ready_o(fifo_in_ready),
      .in_data_i(head_addr),
      .out_valid_o(obj_valid_o),
      .out_ready_i(obj_ready_i),
      .out_data_o(obj_addr_o)
   );

   // Head address: base plus objects of header and payload
   assign head_addr = RAM_BASE + 32'(head[0])
      * 32'(7'(HDR_BYTES) + pay_bytes(ctl[0][B_PLS+:3]));

   // ==========================================================
   // Engine-facing controls
   always_comb begin
      for (int q = 0; q < Q_N; q++) begin
         send_pending_o[q] = req[q] && !empty[q];
         payload_bytes_o[q*7+:7] = pay_bytes(ctl[q][B_PLS+:3]);
         // Without the global option retries are unlimited
         retry_limit_o[q*2+:2] = !global_retry_limit_enable_i ? 2'h2
            : (ctl[q][B_RTY+1] ? 2'h2 : {1'b0, ctl[q][B_RTY]});
      end
   end

   // Higher priority first; tie goes to the queue
   assign next_queue_o = send_pending_o[1] && (!send_pending_o[0]
      || ctl[1][B_PRI+:5] > ctl[0][B_PRI+:5]);
   assign rx_ts_write_o = done[1] && !dir[1] && ctl[1][B_TSE];

   // ==========================================================
   // Interrupt request
   always_comb begin
      ev[0] = stk[0][0] && ctl[0][B_ATIE];
      ev[1] = empty[0] && ctl[0][B_EFIE];
      ev[2] = !full[0] && ctl[0][B_SDIE];
      ev[3] = ovf && ctl[1][B_OVIE];
      ev[4] = (dir[1] ? empty[1] : full[1]) && ctl[1][B_EFIE];
      ev[5] = (dir[1] ? !full[1] : !empty[1]) && ctl[1][B_SDIE];
   end

   assign irq_o = (|ev) || (stk[1][0] && ctl[1][B_ATIE])
      || (ctl[1][B_HLIE] && (dir[1] ? (cnt[1] <= (cap[1] >> 1))
      : (cnt[1] >= (cap[1] >> 1))));

   // ==========================================================
   // Read data
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (reg_index_i)
         IDX_QCON: begin
            next_rdata = ctl[0];
            next_rdata[B_CLR] = clr[0];
            next_rdata[B_REQ] = req[0];
            next_rdata[B_DIR] = 1'b1;
         end
         IDX_QSTA: begin
            next_rdata[B_IDX+:5] = tail[0];
            next_rdata[B_ATF+:4] = stk[0];
            next_rdata[B_EFIE] = empty[0];
            next_rdata[B_SDIE] = !full[0];
         end
         IDX_QUA: begin
            next_rdata = head_addr;
         end
         IDX_FCON: begin
            next_rdata = ctl[1];
            next_rdata[B_CLR] = clr[1];
            next_rdata[B_REQ] = req[1];
         end
         IDX_FSTA: begin
            next_rdata[B_IDX+:5] = tail[1];
            next_rdata[B_ATF+:4] = stk[1];
            next_rdata[B_OVF] = ovf;
            next_rdata[B_EFIE] = dir[1] ? empty[1] : full[1];
            next_rdata[B_HLIE] = dir[1] ? (cnt[1] <= (cap[1] >> 1))
               : (cnt[1] >= (cap[1] >> 1));
            next_rdata[B_SDIE] = dir[1] ? !full[1] : !empty[1];
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   // Read answer one cycle after the strobe
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 32'h0000_0000;
         reg_rvalid_o <= 1'b0;
      end else if (ce_i) begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
         end
      end
   end
endmodule : txq_ctrl

// >>> hw/txq_pkg.sv
/*
 Constants for the transmit queue and message FIFO control block:
 register indices, field positions, reset values and sizes.
 Assumes a host register port with word indices and one
 controller clock.
*/
package txq_pkg;
   // ==========================================================
   // Register indices
   localparam logic [2:0] IDX_QCON = 3'h0;
   localparam logic [2:0] IDX_QSTA = 3'h1;
   localparam logic [2:0] IDX_QUA = 3'h2;
   localparam logic [2:0] IDX_FCON = 3'h3;
   localparam logic [2:0] IDX_FSTA = 3'h4;
   // ==========================================================
   // Control field positions
   localparam int B_PLS = 29;
   localparam int B_DEP = 24;
   localparam int B_RTY = 21;
   localparam int B_PRI = 16;
   localparam int B_CLR = 10;
   localparam int B_REQ = 9;
   localparam int B_ADV = 8;
   localparam int B_DIR = 7;
   localparam int B_RTR = 6;
   localparam int B_TSE = 5;
   localparam int B_ATIE = 4;
   localparam int B_OVIE = 3;
   localparam int B_EFIE = 2;
   localparam int B_HLIE = 1;
   localparam int B_SDIE = 0;
   // ==========================================================
   // Status field positions
   localparam int B_IDX = 8;
   localparam int B_ABT = 7;
   localparam int B_LARB = 6;
   localparam int B_BERR = 5;
   localparam int B_ATF = 4;
   localparam int B_OVF = 3;
   // ==========================================================
   // Write masks, reset value and object RAM base
   localparam logic [31:0] CFG_ONLY = 32'hFF00_00E0;
   localparam logic [31:0] ANY_MODE = 32'h007F_005F;
   localparam logic [31:0] TXQ_BITS = 32'hFF7F_0015;
   localparam logic [31:0] CTL_RST = 32'h0060_0000;
   localparam logic [31:0] RAM_BASE = 32'h0000_0400;
   // ==========================================================
   // Sizes
   localparam int Q_N = 2;
   localparam int FIFO_W = 32;
   localparam int FIFO_D = 32;
   localparam int HDR_BYTES = 8;
endpackage : txq_pkg

// >>> bench/engine_model.sv
/*
 Engine stand-in that takes queue objects from the block.
 Assumes objects are offered on a valid and ready handshake.
*/
`timescale 1ns/1ps
module engine_model (
   // Clock
   input wire logic core_clk_i,
   // Object stream
   input wire logic obj_valid_i,
   output logic obj_ready_o,
   // Test control
   input wire logic stall_i,
   output int taken_o
);
   // ==========================================================
   // Acceptance
   initial begin
      obj_ready_o = 1'b0;
      taken_o = 0;
   end
   // Ready moves just after a rising edge; a stall may last any time
   always @(posedge core_clk_i) begin
      obj_ready_o <= obj_valid_i && !stall_i;
      if (obj_valid_i && obj_ready_o) begin
         taken_o <= taken_o + 1;
      end
   end
endmodule : engine_model

// >>> bench/txq_ctrl_asserts.sv
/*
 Port checks for txq_ctrl, bound to every instance.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module txq_ctrl_asserts
   import txq_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Mode and host port
   input wire logic cfg_mode_i,
   input wire logic global_retry_limit_enable_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [2:0] reg_index_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_rvalid_o,
   // Engine side
   input wire logic [1:0] msg_done_i,
   input wire logic [1:0] aborted_i,
   input wire logic [1:0] send_pending_o,
   input wire logic [1:0] abort_req_o,
   input wire logic [3:0] retry_limit_o,
   input wire logic [13:0] payload_bytes_o,
   input wire logic rx_ts_write_o,
   input wire logic obj_valid_o,
   input wire logic obj_ready_i,
   input wire logic [FIFO_W-1:0] obj_addr_o
);
   logic drop_req;
   logic drop_q;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================================
   // Helpers
   assign drop_req = ce_i && reg_wr_i && reg_index_i == IDX_QCON && !reg_wdata_i[B_REQ];
   always_ff @(posedge core_clk_i) begin
      drop_q <= rst_n_i && drop_req;
   end
   // ==========================================================
   // Properties
   chk_read_answer: assert property (ce_i && reg_rd_i |=> reg_rvalid_o)
      else $error("read without read valid");
   chk_read_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
      else $error("read valid without read");
   chk_abort_raise: assert property (
      drop_req && !reg_wdata_i[B_CLR] && !cfg_mode_i && send_pending_o[0] |=> abort_req_o[0])
      else $error("no abort after request drop");
   chk_abort_cause: assert property (abort_req_o[0] |-> drop_q)
      else $error("abort without request drop");
   chk_retry_default: assert property (
      !global_retry_limit_enable_i |-> retry_limit_o == 4'hA)
      else $error("retry not unlimited with global option off");
   chk_payload_legal: assert property (
      payload_bytes_o[6:0] inside {7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40})
      else $error("payload size not a legal byte count");
   chk_ts_with_store: assert property (rx_ts_write_o |-> msg_done_i[1])
      else $error("time stamp write without stored message");
   // Abort cycles and configuration flushes are excluded on purpose
   chk_obj_holds: assert property (
      obj_valid_o && !obj_ready_i && !cfg_mode_i && aborted_i == 2'h0
      |=> obj_valid_o && $stable(obj_addr_o))
      else $error("queue object dropped or changed while stalled");
   cover property (abort_req_o[0]);
   cover property (obj_valid_o && obj_ready_i);
   cover property (rx_ts_write_o);
endmodule : txq_ctrl_asserts

bind txq_ctrl txq_ctrl_asserts u_txq_asserts (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .cfg_mode_i(cfg_mode_i),
   .global_retry_limit_enable_i(global_retry_limit_enable_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_index_i(reg_index_i), .reg_wdata_i(reg_wdata_i),
   .reg_rvalid_o(reg_rvalid_o), .msg_done_i(msg_done_i), .aborted_i(aborted_i),
   .send_pending_o(send_pending_o), .abort_req_o(abort_req_o),
   .retry_limit_o(retry_limit_o), .payload_bytes_o(payload_bytes_o),
   .rx_ts_write_o(rx_ts_write_o), .obj_valid_o(obj_valid_o), .obj_ready_i(obj_ready_i),
   .obj_addr_o(obj_addr_o)
);

// >>> bench/testbench.sv
/*
 Self-checking bench: host register tasks, engine stand-in, directed runs.
 Assumes the package constants and a 125 MHz clock.
*/
`timescale 1ns/1ps
module testbench
   import txq_pkg::*;
;
   localparam logic [6:0] PL_BYTES [8] = '{7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
   localparam logic [31:0] QB = 32'h003F_0000;
   logic core_clk_i, rst_n_i, ce_i, cfg_mode_i, global_retry_limit_enable_i, stall;
   logic reg_wr_i, reg_rd_i, reg_rvalid_o, remote_req_i, next_queue_o, rx_ts_write_o, irq_o;
   logic obj_valid_o, obj_ready_i;
   logic [2:0] reg_index_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, rd_val;
   logic [1:0] msg_done_i, aborted_i, arb_lost_i, bus_err_i, attempts_out_i;
   logic [1:0] send_pending_o, abort_req_o;
   logic [3:0] retry_limit_o;
   logic [13:0] payload_bytes_o;
   logic [FIFO_W-1:0] obj_addr_o;
   int err_count, tests_run, taken;

   txq_ctrl DUT (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .cfg_mode_i(cfg_mode_i),
      .global_retry_limit_enable_i(global_retry_limit_enable_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_index_i(reg_index_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .msg_done_i(msg_done_i),
      .aborted_i(aborted_i), .arb_lost_i(arb_lost_i), .bus_err_i(bus_err_i),
      .attempts_out_i(attempts_out_i), .remote_req_i(remote_req_i),
      .send_pending_o(send_pending_o), .abort_req_o(abort_req_o),
      .retry_limit_o(retry_limit_o), .payload_bytes_o(payload_bytes_o),
      .next_queue_o(next_queue_o), .rx_ts_write_o(rx_ts_write_o), .irq_o(irq_o),
      .obj_valid_o(obj_valid_o), .obj_ready_i(obj_ready_i), .obj_addr_o(obj_addr_o)
   );
   engine_model u_engine (
      .core_clk_i(core_clk_i), .obj_valid_i(obj_valid_o), .obj_ready_o(obj_ready_i),
      .stall_i(stall), .taken_o(taken)
   );
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   // ==========================================================
   // Tasks
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [2:0] idx, input logic [31:0] d);
      @(negedge core_clk_i);
      reg_wr_i = 1'b1;
      reg_index_i = idx;
      reg_wdata_i = d;
      @(negedge core_clk_i);
      reg_wr_i = 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] idx);
      @(negedge core_clk_i);
      reg_rd_i = 1'b1;
      reg_index_i = idx;
      @(negedge core_clk_i);
      reg_rd_i = 1'b0;
      rd_val = reg_rdata_o;
      chk("rvalid", {31'h0, reg_rvalid_o}, 32'h1);
   endtask : rd
   // Bounded wait so a stuck handshake cannot hang the run
   task automatic drain;
      stall = 1'b0;
      for (int k = 0; k < 40 && obj_valid_o !== 1'b0; k++) begin
         @(negedge core_clk_i);
      end
      repeat (3) @(negedge core_clk_i);
      stall = 1'b1;
      chk("drained", {31'h0, obj_valid_o}, 32'h0);
   endtask : drain
   function automatic logic [1:0] rmap(input logic [1:0] c);
      return (c == 2'h0) ? 2'h0 : ((c == 2'h1) ? 2'h1 : 2'h2);
   endfunction : rmap
   task automatic conclude;
      if (err_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   // ==========================================================
   // Sequence
   initial begin
      {ce_i, cfg_mode_i, stall} = 3'h7;
      {rst_n_i, global_retry_limit_enable_i, reg_wr_i, reg_rd_i, remote_req_i} = 5'h00;
      {msg_done_i, aborted_i, arb_lost_i, bus_err_i, attempts_out_i} = 10'h000;
      reg_index_i = 3'h0;
      reg_wdata_i = 32'h0;
      err_count = 0;
      tests_run = 0;
      repeat (20) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      rd(IDX_QCON);
      chk("qcon_rst", rd_val, 32'h0060_0480);
      rd(IDX_QSTA);
      chk("qsta_rst", rd_val, 32'h0000_0005);
      chk("retry_off", {28'h0, retry_limit_o}, 32'h0000_000A);
      global_retry_limit_enable_i = 1'b1;
      for (int i = 0; i < 8; i++) begin
         wr(IDX_QCON, {i[2:0], 5'h01, 1'b0, i[1:0], 21'h0});
         chk("bytes", {25'h0, payload_bytes_o[6:0]}, {25'h0, PL_BYTES[i]});
         chk("retry", {30'h0, retry_limit_o[1:0]}, {30'h0, rmap(i[1:0])});
      end
      rd(IDX_QCON);
      chk("dir_fixed", {31'h0, rd_val[B_DIR]}, 32'h1);
      wr(IDX_QCON, QB | 32'h0120_0004);
      wr(IDX_FCON, 32'h0000_00C0);
      chk("irq_on", {31'h0, irq_o}, 32'h1);
      chk("order_q", {31'h0, next_queue_o}, 32'h0);
      cfg_mode_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      wr(IDX_QCON, 32'h1F3F_0004);
      rd(IDX_QCON);
      chk("clr_rel", {31'h0, rd_val[B_CLR]}, 32'h0);
      chk("depth_lock", {27'h0, rd_val[28:24]}, 32'h1);
      rd(IDX_QUA);
      chk("head0", rd_val, RAM_BASE);
      wr(IDX_QCON, QB | 32'h0000_0104);
      rd(IDX_QUA);
      chk("head1", rd_val, RAM_BASE + 32'h10);
      chk("obj_addr", obj_addr_o, RAM_BASE);
      wr(IDX_QCON, QB | 32'h0000_0104);
      wr(IDX_QCON, QB | 32'h0000_0104);
      rd(IDX_QSTA);
      chk("full", rd_val & 32'h5, 32'h0);
      rd(IDX_QUA);
      chk("wrap", rd_val, RAM_BASE);
      wr(IDX_QCON, QB | 32'h0000_0204);
      chk("pending", {30'h0, send_pending_o}, 32'h1);
      drain();
      rd(IDX_QCON);
      chk("req_done", {31'h0, rd_val[B_REQ]}, 32'h0);
      chk("taken", 32'(taken), 32'h2);
      wr(IDX_QCON, QB | 32'h0000_0104);
      wr(IDX_QCON, QB | 32'h0000_0204);
      wr(IDX_QCON, QB | 32'h0000_0004);
      chk("abort", {30'h0, abort_req_o}, 32'h1);
      rd(IDX_QCON);
      chk("req_hold", {31'h0, rd_val[B_REQ]}, 32'h1);
      {aborted_i, arb_lost_i, bus_err_i, attempts_out_i} = 8'h55;
      @(negedge core_clk_i);
      {aborted_i, arb_lost_i, bus_err_i, attempts_out_i} = 8'h00;
      rd(IDX_QCON);
      chk("req_abt", {31'h0, rd_val[B_REQ]}, 32'h0);
      rd(IDX_QSTA);
      chk("flags", rd_val & 32'hF1, 32'hF1);
      wr(IDX_QSTA, 32'h0);
      rd(IDX_QSTA);
      chk("flags_clr", rd_val & 32'hF0, 32'h0);
      drain();
      wr(IDX_QCON, QB | 32'h0000_0404);
      repeat (2) @(negedge core_clk_i);
      rd(IDX_QCON);
      chk("clr_done", {31'h0, rd_val[B_CLR]}, 32'h0);
      rd(IDX_QUA);
      chk("head_rst", rd_val, RAM_BASE);
      chk("irq_en", {31'h0, irq_o}, 32'h1);
      wr(IDX_QCON, QB);
      chk("irq_mask", {31'h0, irq_o}, 32'h0);
      rd(IDX_QSTA);
      chk("flag_kept", {31'h0, rd_val[2]}, 32'h1);
      wr(IDX_FCON, 32'h0001_01C0);
      remote_req_i = 1'b1;
      @(negedge core_clk_i);
      remote_req_i = 1'b0;
      rd(IDX_FCON);
      chk("autoreply", {31'h0, rd_val[B_REQ]}, 32'h1);
      wr(IDX_QCON, 32'h0020_0100);
      wr(IDX_QCON, 32'h0020_0200);
      chk("order_f", {31'h0, next_queue_o}, 32'h1);
      cfg_mode_i = 1'b1;
      wr(IDX_FCON, 32'hE000_0020);
      chk("fifo_bytes", {25'h0, payload_bytes_o[13:7]}, {25'h0, PL_BYTES[7]});
      cfg_mode_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      msg_done_i = 2'h2;
      #1;
      chk("ts_write", {31'h0, rx_ts_write_o}, 32'h1);
      @(negedge core_clk_i);
      msg_done_i = 2'h0;
      wr(IDX_FCON, 32'h0000_0220);
      chk("rx_req", {31'h0, send_pending_o[1]}, 32'h0);
      wr(IDX_FCON, 32'h0000_0100);
      rd(IDX_FSTA);
      chk("rx_tail", rd_val & 32'h1, 32'h0);
      conclude();
   end
   // Run takes well under a thousand cycles
   initial begin
      #100000;
      err_count++;
      conclude();
   end
endmodule : testbench
